// File: core/asc_pkg.sv
// Package of constants and types for the axis stop command logic
package asc_pkg;
	// ==========================================
	// Control types of an axis
	typedef enum logic [2:0] {
		asc_ctl_idle_type,
		asc_ctl_position_type,
		asc_ctl_speed_type,
		asc_ctl_jog_type,
		asc_ctl_fixed_stop_type,
		asc_ctl_manual_pulse_type,
		asc_ctl_home_return_type,
		asc_ctl_speed_torque_type
	} asc_ctl_type;
	// ==========================================
	// Control type codes at the mode input
	localparam logic [2:0] ASC_MODE_IDLE = 3'h0;
	localparam logic [2:0] ASC_MODE_POSITION = 3'h1;
	localparam logic [2:0] ASC_MODE_SPEED = 3'h2;
	localparam logic [2:0] ASC_MODE_JOG = 3'h3;
	localparam logic [2:0] ASC_MODE_FIXED_STOP = 3'h4;
	localparam logic [2:0] ASC_MODE_MANUAL_PULSE = 3'h5;
	localparam logic [2:0] ASC_MODE_HOME_RETURN = 3'h6;
	localparam logic [2:0] ASC_MODE_SPEED_TORQUE = 3'h7;
	// ==========================================
	// Error codes and reset values
	localparam logic [15:0] ASC_ERR_HOME_STOP = 16'h00ca;
	localparam logic [15:0] ASC_ERR_NONE = 16'h0000;
	localparam logic [15:0] ASC_SPEED_ZERO = 16'h0000;
	localparam int ASC_ERR_W = 16;
	localparam int ASC_SPEED_W = 16;
	localparam int ASC_DECEL_W = 16;
endpackage

// File: core/asc_edge_det.sv
// Rising edge detector for one command bit
`timescale 1ns/1ps
module asc_edge_det (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Level and edge
	input wire logic level_i,
	output logic rise_o
);
	logic prev;
	// ==========================================
	// Previous-cycle sample
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev <= 1'b0;
		end else if (ce_i) begin
			prev <= level_i;
		end
	end
	// Edge is the current sample high against a low previous one
	assign rise_o = level_i & ~prev;
endmodule

// File: core/asc_decel_timer.sv
// Deceleration ramp countdown for one axis
`timescale 1ns/1ps
module asc_decel_timer #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Control
	input wire logic load_i,
	input wire logic [W-1:0] time_i,
	input wire logic abort_i,
	output logic busy_o,
	output logic done_o
);
	logic [W-1:0] count;
	// ==========================================
	// A load while counting is ignored so a running ramp stays unchanged
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count <= '0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else if (ce_i) begin
			done_o <= 1'b0;
			if (abort_i) begin
				count <= '0;
				busy_o <= 1'b0;
			end else if (load_i && !busy_o) begin
				count <= time_i;
				busy_o <= 1'b1;
			end else if (busy_o) begin
				if (count == '0) begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end else begin
					count <= count - W'(1);
				end
			end
		end
	end
endmodule

// File: core/asc_axis_stop.sv
// Per-axis stop and rapid stop command handling
// ==========================================
`timescale 1ns/1ps
module asc_axis_stop
	import asc_pkg::*;
#(
	parameter int DECEL_W = ASC_DECEL_W,
	parameter int SPEED_W = ASC_SPEED_W
) (
	// Clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Command bits from the command source
	input wire logic axis_stop_cmd_bit_i,
	input wire logic axis_rapid_halt_cmd_bit_i,
	// Start request and its mode
	input wire logic start_req_i,
	input wire logic [2:0] start_mode_i,
	input wire logic [DECEL_W-1:0] decel_time_i,
	input wire logic [DECEL_W-1:0] param_decel_time_i,
	// Motion status from the profile logic
	input wire logic motion_end_i,
	input wire logic dwell_i,
	input wire logic dwell_end_i,
	input wire logic zero_speed_i,
	input wire logic [SPEED_W-1:0] speed_cmd_i,
	input wire logic err_clear_i,
	// Status
	output logic axis_start_accept_flag_o,
	output logic axis_position_done_flag_o,
	output logic [ASC_ERR_W-1:0] axis_minor_error_word_o,
	output logic [SPEED_W-1:0] speed_cmd_o,
	output logic decel_active_o,
	output logic rapid_halt_o,
	output logic start_refused_o,
	output logic [2:0] ctl_mode_o
);
	// ==========================================
	// Signals
	asc_ctl_type ctl;
	asc_ctl_type next_ctl;
	logic stop_rise;
	logic rapid_rise;
	logic stopping_st;
	logic next_stopping_st;
	logic decel_busy;
	logic decel_done;
	logic decel_load;
	logic [DECEL_W-1:0] decel_sel;
	logic ramp_mode;
	logic running;
	logic start_ok;
	logic start_block;
	logic stop_take;
	logic dwell_end_take;
	logic start_refuse;
	logic rapid_take;
	logic pulse_halt;
	logic torque_stop;
	logic ramp_stop;
	logic home_stop;
	logic torque_end;
	logic ramp_end;
	logic plain_end;
	logic go_idle;
	logic speed_pass;

	// Decode of the mode code into a control type, used at start
	function automatic asc_ctl_type mode_decode(input logic [2:0] m);
		unique case (m)
			ASC_MODE_IDLE: mode_decode = asc_ctl_idle_type;
			ASC_MODE_POSITION: mode_decode = asc_ctl_position_type;
			ASC_MODE_SPEED: mode_decode = asc_ctl_speed_type;
			ASC_MODE_JOG: mode_decode = asc_ctl_jog_type;
			ASC_MODE_FIXED_STOP: mode_decode = asc_ctl_fixed_stop_type;
			ASC_MODE_MANUAL_PULSE: mode_decode = asc_ctl_manual_pulse_type;
			ASC_MODE_HOME_RETURN: mode_decode = asc_ctl_home_return_type;
			ASC_MODE_SPEED_TORQUE: mode_decode = asc_ctl_speed_torque_type;
		endcase
	endfunction

	// Mode back to its code for the status output
	function automatic logic [2:0] mode_encode(input asc_ctl_type c);
		unique case (c)
			asc_ctl_idle_type: mode_encode = ASC_MODE_IDLE;
			asc_ctl_position_type: mode_encode = ASC_MODE_POSITION;
			asc_ctl_speed_type: mode_encode = ASC_MODE_SPEED;
			asc_ctl_jog_type: mode_encode = ASC_MODE_JOG;
			asc_ctl_fixed_stop_type: mode_encode = ASC_MODE_FIXED_STOP;
			asc_ctl_manual_pulse_type: mode_encode = ASC_MODE_MANUAL_PULSE;
			asc_ctl_home_return_type: mode_encode = ASC_MODE_HOME_RETURN;
			asc_ctl_speed_torque_type: mode_encode = ASC_MODE_SPEED_TORQUE;
		endcase
	endfunction

	// ==========================================
	// Edge detection of the command bits
	// Command bits come from logic on this clock, so no synchroniser
	asc_edge_det u_stop_edge (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.level_i(axis_stop_cmd_bit_i),
		.rise_o(stop_rise)
	);
	asc_edge_det u_rapid_edge (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.level_i(axis_rapid_halt_cmd_bit_i),
		.rise_o(rapid_rise)
	);

	// ==========================================
	// Deceleration ramp
	asc_decel_timer #(
		.W(DECEL_W)
	) u_decel (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.load_i(decel_load),
		.time_i(decel_sel),
		.abort_i(rapid_rise),
		.busy_o(decel_busy),
		.done_o(decel_done)
	);

	// ==========================================
	// Decoding of the stop action
	assign running = (ctl != asc_ctl_idle_type);
	// A held command bit blocks a start; a level, not an edge
	assign start_block = axis_stop_cmd_bit_i | axis_rapid_halt_cmd_bit_i;
	assign start_ok = start_req_i & ~running & ~start_block;
	assign start_refuse = start_req_i & ~running & start_block;
	// Rapid stop only matters on a moving axis; on an idle one it is dropped
	assign rapid_take = rapid_rise & running;
	// Stops in a dwell are dropped
	assign stop_take = stop_rise & running & ~dwell_i & ~stopping_st;
	assign dwell_end_take = dwell_end_i & running;
	assign ramp_mode = (ctl == asc_ctl_position_type) | (ctl == asc_ctl_speed_type)
		| (ctl == asc_ctl_jog_type) | (ctl == asc_ctl_fixed_stop_type)
		| (ctl == asc_ctl_home_return_type);
	assign decel_load = stop_take & ramp_mode & ~rapid_rise;
	// Home return always uses the parameter block time
	assign decel_sel = (ctl == asc_ctl_home_return_type) ? param_decel_time_i
		: decel_time_i;

	// ==========================================
	// Stop actions per control type
	assign pulse_halt = stop_take & (ctl == asc_ctl_manual_pulse_type);
	assign torque_stop = stop_take & (ctl == asc_ctl_speed_torque_type);
	assign ramp_stop = stop_take & ramp_mode;
	assign home_stop = stop_take & (ctl == asc_ctl_home_return_type) & ~rapid_rise;
	// Zero speed is only trusted once the torque stop has zeroed the command
	assign torque_end = stopping_st & (ctl == asc_ctl_speed_torque_type) & zero_speed_i;
	assign ramp_end = stopping_st & decel_done;
	// A motion end input is ignored while a stop is in progress; a dwell end still ends motion
	assign plain_end = dwell_end_take | (motion_end_i & ~stopping_st);
	// Leaving motion by any path drops the start-accept flag
	assign go_idle = running & (next_ctl == asc_ctl_idle_type);
	assign speed_pass = (next_ctl == asc_ctl_speed_torque_type) & ~next_stopping_st;

	// ==========================================
	// Next control type and stopping state
	// Priority: start, rapid stop, stop by type, stop completion, normal end
	always_comb begin
		next_ctl = ctl;
		next_stopping_st = stopping_st;
		if (start_ok) begin
			next_ctl = mode_decode(start_mode_i);
			next_stopping_st = 1'b0;
		end else if (rapid_take) begin
			// Rapid stop overrides any mode and any ramp in progress
			next_ctl = asc_ctl_idle_type;
			next_stopping_st = 1'b0;
		end else if (pulse_halt) begin
			next_ctl = asc_ctl_idle_type;
		end else if (torque_stop) begin
			next_stopping_st = 1'b1;
		end else if (ramp_stop) begin
			next_stopping_st = 1'b1;
		end else if (torque_end) begin
			// Zero speed ends the torque stop, and the axis goes straight to idle
			next_ctl = asc_ctl_idle_type;
			next_stopping_st = 1'b0;
		end else if (ramp_end) begin
			next_ctl = asc_ctl_idle_type;
			next_stopping_st = 1'b0;
		end else if (plain_end) begin
			next_ctl = asc_ctl_idle_type;
		end
	end

	// ==========================================
	// Control state
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctl <= asc_ctl_idle_type;
			stopping_st <= 1'b0;
		end else if (ce_i) begin
			ctl <= next_ctl;
			stopping_st <= next_stopping_st;
		end
	end

	// ==========================================
	// Start accept flag
	// Cleared whenever a running axis returns to idle, whatever the cause
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			axis_start_accept_flag_o <= 1'b0;
		end else if (ce_i) begin
			if (start_ok) begin
				axis_start_accept_flag_o <= 1'b1;
			end else if (dwell_end_take) begin
				axis_start_accept_flag_o <= 1'b0;
			end else if (go_idle) begin
				axis_start_accept_flag_o <= 1'b0;
			end
		end
	end

	// ==========================================
	// Positioning complete flag
	// Only a dwell end sets it, even one during a stop; a stop that ends the motion leaves it clear
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			axis_position_done_flag_o <= 1'b0;
		end else if (ce_i) begin
			if (start_ok) begin
				axis_position_done_flag_o <= 1'b0;
			end else if (dwell_end_take) begin
				axis_position_done_flag_o <= 1'b1;
			end
		end
	end

	// ==========================================
	// Minor error word; the set wins over a clear in the same cycle
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			axis_minor_error_word_o <= ASC_ERR_NONE;
		end else if (ce_i) begin
			if (home_stop) begin
				axis_minor_error_word_o <= ASC_ERR_HOME_STOP;
			end else if (err_clear_i) begin
				axis_minor_error_word_o <= ASC_ERR_NONE;
			end
		end
	end

	// ==========================================
	// Speed command to the amplifier
	// Zero is held while a torque-mode stop waits for zero speed
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			speed_cmd_o <= ASC_SPEED_ZERO;
		end else if (ce_i) begin
			if (speed_pass) begin
				speed_cmd_o <= speed_cmd_i;
			end else begin
				speed_cmd_o <= ASC_SPEED_ZERO;
			end
		end
	end

	// ==========================================
	// Stop processing status, a copy of the stopping state
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			decel_active_o <= 1'b0;
		end else if (ce_i) begin
			decel_active_o <= next_stopping_st;
		end
	end

	// ==========================================
	// One-cycle event outputs
	// Rewritten every enabled cycle, so each pulse falls by itself
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rapid_halt_o <= 1'b0;
			start_refused_o <= 1'b0;
		end else if (ce_i) begin
			rapid_halt_o <= rapid_take;
			start_refused_o <= start_refuse;
		end
	end

	// ==========================================
	// Control type code for the status output
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctl_mode_o <= ASC_MODE_IDLE;
		end else if (ce_i) begin
			ctl_mode_o <= mode_encode(next_ctl);
		end
	end
endmodule

// File: bench/asc_axis_stop_sva.sv
// Checker for the axis stop command logic
`timescale 1ns/1ps
module asc_axis_stop_sva
	import asc_pkg::*;
#(
	parameter int DECEL_W = ASC_DECEL_W,
	parameter int SPEED_W = ASC_SPEED_W
) (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Inputs
	input wire logic axis_stop_cmd_bit_i,
	input wire logic axis_rapid_halt_cmd_bit_i,
	input wire logic start_req_i,
	input wire logic dwell_i,
	input wire logic dwell_end_i,
	input wire logic zero_speed_i,
	// Outputs
	input wire logic axis_start_accept_flag_o,
	input wire logic axis_position_done_flag_o,
	input wire logic [ASC_ERR_W-1:0] axis_minor_error_word_o,
	input wire logic [SPEED_W-1:0] speed_cmd_o,
	input wire logic decel_active_o,
	input wire logic rapid_halt_o,
	input wire logic start_refused_o,
	input wire logic [2:0] ctl_mode_o
);
	logic prev_stop;
	logic prev_rapid;
	// Previous samples follow the clock enable, as an edge is only seen on enabled cycles
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev_stop <= 1'b0;
			prev_rapid <= 1'b0;
		end else if (ce_i) begin
			prev_stop <= axis_stop_cmd_bit_i;
			prev_rapid <= axis_rapid_halt_cmd_bit_i;
		end
	end
	// Edge decode
	wire rapid_edge = ce_i && axis_rapid_halt_cmd_bit_i && !prev_rapid;
	wire stop_edge = ce_i && axis_stop_cmd_bit_i && !prev_stop && !rapid_edge && !dwell_end_i;
	wire stop_live = stop_edge && !dwell_i && !decel_active_o;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// ==========================================
	// Sequences
	sequence s_halted;
		ctl_mode_o == ASC_MODE_IDLE && !axis_start_accept_flag_o && !decel_active_o;
	endsequence
	sequence s_ramping;
		decel_active_o && ctl_mode_o == $past(ctl_mode_o);
	endsequence
	// ==========================================
	// Assertions
	AST_REFUSE: assert property (ce_i && start_req_i && ctl_mode_o == ASC_MODE_IDLE
		&& (axis_stop_cmd_bit_i || axis_rapid_halt_cmd_bit_i) |=> start_refused_o ##0 s_halted)
		else $error("start taken while a command bit was high");
	AST_RAMP: assert property (stop_live && ctl_mode_o inside {[1:4], 6} |=> s_ramping)
		else $error("stop edge did not begin a ramp");
	AST_HOME_ERR: assert property (stop_live && ctl_mode_o == ASC_MODE_HOME_RETURN
		|=> axis_minor_error_word_o == ASC_ERR_HOME_STOP) else $error("home stop error missing");
	AST_PULSE_HALT: assert property (stop_live && ctl_mode_o == ASC_MODE_MANUAL_PULSE
		|=> s_halted) else $error("manual pulse axis not halted at once");
	AST_TORQUE_ZERO: assert property (stop_live && ctl_mode_o == ASC_MODE_SPEED_TORQUE
		|=> speed_cmd_o == ASC_SPEED_ZERO && decel_active_o) else $error("speed not zeroed");
	AST_TORQUE_END: assert property (ce_i && decel_active_o && zero_speed_i
		&& ctl_mode_o == ASC_MODE_SPEED_TORQUE |=> s_halted) else $error("torque stop not ended");
	AST_DWELL_IGNORE: assert property (stop_edge && dwell_i && !decel_active_o
		&& ctl_mode_o != ASC_MODE_IDLE |=> !decel_active_o && ctl_mode_o == $past(ctl_mode_o))
		else $error("stop acted during dwell");
	AST_DWELL_END: assert property (ce_i && dwell_end_i && axis_start_accept_flag_o
		&& !rapid_edge |=> !axis_start_accept_flag_o && axis_position_done_flag_o)
		else $error("dwell end flags wrong");
	AST_RAPID: assert property (rapid_edge && ctl_mode_o != ASC_MODE_IDLE
		|=> rapid_halt_o ##0 s_halted ##1 !rapid_halt_o) else $error("rapid stop not taken");
endmodule
bind asc_axis_stop asc_axis_stop_sva #(.DECEL_W(DECEL_W), .SPEED_W(SPEED_W)) chk (.*);

// File: bench/asc_servo_model.sv
// Servo amplifier stand-in reporting zero speed after the command falls
`timescale 1ns/1ps
module asc_servo_model (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Command side
	input wire logic torque_run_i,
	input wire logic [15:0] speed_cmd_i,
	input wire logic [3:0] lag_i,
	// Feedback
	output logic zero_speed_o
);
	logic [3:0] settle;
	// The motor coasts for lag_i cycles after the command is zero, so zero speed comes at once when lag_i is 0
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			settle <= 4'h0;
		end else if (!torque_run_i || speed_cmd_i != 16'h0000) begin
			settle <= 4'h0;
		end else if (settle != lag_i) begin
			settle <= settle + 4'h1;
		end
	end
	assign zero_speed_o = torque_run_i && settle == lag_i && speed_cmd_i == 16'h0000;
endmodule

// File: bench/asc_axis_stop_tb_top.sv
// Self-checking testbench for the axis stop command logic
`timescale 1ns/1ps
module asc_axis_stop_tb_top;
	import asc_pkg::*;
	logic sys_clk_i, rst_n_i, ce_i, stop_b, rapid_b, start_req, dwell, dwell_end, err_clr, m_end;
	logic accept, done, decel, rhalt, refused, zero_spd;
	logic [2:0] mode, ctl;
	logic [3:0] lag;
	logic [15:0] spd_out, err_w;
	int fail_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	asc_axis_stop uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
		.axis_stop_cmd_bit_i(stop_b), .axis_rapid_halt_cmd_bit_i(rapid_b),
		.start_req_i(start_req), .start_mode_i(mode), .decel_time_i(16'h0008),
		.param_decel_time_i(16'h000c), .motion_end_i(m_end), .dwell_i(dwell),
		.dwell_end_i(dwell_end), .zero_speed_i(zero_spd), .speed_cmd_i(16'h1234),
		.err_clear_i(err_clr), .axis_start_accept_flag_o(accept),
		.axis_position_done_flag_o(done), .axis_minor_error_word_o(err_w),
		.speed_cmd_o(spd_out), .decel_active_o(decel), .rapid_halt_o(rhalt),
		.start_refused_o(refused), .ctl_mode_o(ctl));
	asc_servo_model amp (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .lag_i(lag),
		.torque_run_i(ctl == ASC_MODE_SPEED_TORQUE), .speed_cmd_i(spd_out), .zero_speed_o(zero_spd));
	// Clock and hang limit
	initial begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end
	always @(posedge sys_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fail_count++;
			wrap_up();
		end
	end
	// ==========================================
	// Shared tasks
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic look();
		@(posedge sys_clk_i);
		#1;
	endtask
	task automatic do_reset(input logic [3:0] lg);
		if ($time > 0) @(posedge sys_clk_i);
		{rst_n_i, stop_b, rapid_b, start_req, dwell, dwell_end, err_clr, m_end} <= 8'h00;
		ce_i <= 1'b1;
		mode <= 3'h0;
		lag <= lg;
		repeat (4) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
	endtask
	task automatic go(input logic [2:0] m);
		@(posedge sys_clk_i);
		start_req <= 1'b1;
		mode <= m;
		look();
		start_req <= 1'b0;
		check("mode", {13'h0, ctl}, {13'h0, m});
	endtask
	task automatic stop_now();
		@(posedge sys_clk_i);
		stop_b <= 1'b1;
		look();
	endtask
	// Counts cycles of stop processing, stopping after a bound so a stuck ramp is seen
	task automatic ramp_len(output int n);
		n = 0;
		while (decel === 1'b1 && n < 60) begin
			look();
			n++;
		end
	endtask
	// ==========================================
	// Scenarios
	task automatic t_refuse(input logic which);
		do_reset(4'h1);
		@(posedge sys_clk_i);
		{stop_b, rapid_b} <= {!which, which};
		start_req <= 1'b1;
		mode <= ASC_MODE_POSITION;
		look();
		check("refused", {15'h0, refused}, 16'h0001);
		check("accept", {15'h0, accept}, 16'h0000);
		$display("refuse test done");
	endtask
	task automatic t_ramp(input logic [2:0] m, input int len);
		int n;
		do_reset(4'h1);
		go(m);
		stop_now();
		check("decel", {15'h0, decel}, 16'h0001);
		stop_b <= 1'b0;
		look();
		stop_b <= 1'b1;
		ramp_len(n);
		check("ramp fits", {15'h0, n == len + 1}, 16'h0001);
		check("idle", {13'h0, ctl}, 16'h0000);
		$display("ramp test done");
	endtask
	task automatic t_home();
		t_ramp(ASC_MODE_HOME_RETURN, 12);
		check("error", err_w, ASC_ERR_HOME_STOP);
		err_clr <= 1'b1;
		stop_b <= 1'b0;
		look();
		err_clr <= 1'b0;
		check("error", err_w, 16'h0000);
		go(ASC_MODE_HOME_RETURN); // Home return issued again after the stop
		$display("home test done");
	endtask
	task automatic t_fast(input logic [2:0] m, input logic [3:0] lg);
		int n;
		do_reset(lg);
		go(m);
		check("speed", spd_out, m == ASC_MODE_SPEED_TORQUE ? 16'h1234 : 16'h0000);
		stop_now();
		check("speed", spd_out, 16'h0000);
		ramp_len(n);
		check("zero wait", n[15:0], (m == ASC_MODE_SPEED_TORQUE) ? 16'(lg) + 16'h0001 : 16'h0000);
		check("idle", {13'h0, ctl}, 16'h0000);
		$display("immediate and torque test done");
	endtask
	task automatic t_dwell();
		do_reset(4'h1);
		go(ASC_MODE_POSITION);
		dwell <= 1'b1;
		stop_now();
		check("decel", {15'h0, decel}, 16'h0000);
		dwell_end <= 1'b1;
		dwell <= 1'b0;
		look();
		dwell_end <= 1'b0;
		check("flags", {14'h0, accept, done}, 16'h0001);
		$display("dwell test done");
	endtask
	task automatic t_rapid();
		do_reset(4'h1);
		go(ASC_MODE_JOG);
		@(posedge sys_clk_i);
		{stop_b, rapid_b} <= 2'b11;
		look();
		check("halt", {14'h0, rhalt, decel}, 16'h0002);
		look();
		check("halt", {12'h0, rhalt, ctl}, 16'h0000);
		$display("rapid test done");
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		t_refuse(1'b0);
		t_refuse(1'b1);
		for (int m = 1; m <= 4; m++) begin
			t_ramp(3'(m), 8);
		end
		t_home();
		t_fast(ASC_MODE_MANUAL_PULSE, 4'h0);
		t_fast(ASC_MODE_SPEED_TORQUE, 4'h1);
		t_fast(ASC_MODE_SPEED_TORQUE, 4'h7);
		t_dwell();
		t_rapid();
		wrap_up();
	end
endmodule
